// ---- core/sleep_ctrl_pkg.sv ----
// Shared constants and types for the sleep mode clock gating block.
// Assumes one 200 MHz reference clock and a synchronous active-high reset.
`default_nettype none
package sleep_ctrl_pkg;
	// ----------------------------------------
	// Sleep mode select encodings
	// ----------------------------------------
	localparam logic [2:0] MODE_IDLE       = 3'h0;
	localparam logic [2:0] MODE_NOISE_RED  = 3'h1;
	localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
	localparam logic [2:0] MODE_POWER_SAVE = 3'h3;
	localparam logic [2:0] MODE_STANDBY    = 3'h6;

	// ----------------------------------------
	// Timing counts
	// ----------------------------------------
	localparam int CLK_PERIOD_NS     = 5;
	localparam int WAKE_HALT_CYCLES  = 4;   // Halt after an interrupt wake-up
	localparam int STANDBY_CYCLES    = 6;   // Resume time from standby
	localparam int STARTUP_DEFAULT   = 6;   // Default oscillator start-up, in cycles
	localparam logic [15:0] STARTUP_RST = 16'h0000;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	// Clock enables handed to the clock tree, one per domain
	typedef struct packed {
		logic core;
		logic prog_mem;
		logic periph;
		logic conv;
		logic async_tmr;
		logic main_osc;
		logic timer_osc;
	} clk_en_t;

	// Wake-up sources, already qualified by their own enables
	typedef struct packed {
		logic any_irq;        // Any enabled interrupt
		logic conv_done;
		logic ext_reset;
		logic wdt_reset;
		logic bod_reset;
		logic twi_match;
		logic timer2_irq;     // Overflow or compare, mask already applied
		logic spm_ee_ready;
		logic ext_level;      // Level interrupt on ext_irq_0 or ext_irq_1
	} wake_src_t;

	typedef enum logic [2:0] {
		ST_RUN    = 3'h0,
		ST_SLEEP  = 3'h1,
		ST_START  = 3'h2,
		ST_HALT   = 3'h3
	} sleep_state_t;
endpackage
`default_nettype wire

// ---- core/sleep_mode_decode.sv ----
// Decodes the sleep mode select field into clock enables and allowed wake sources.
// Assumes the caller only uses the outputs on the cycle the sleep instruction executes.
`default_nettype none
module sleep_mode_decode
	import sleep_ctrl_pkg::*;
(
	input  wire logic [2:0] i_mode,          // Sleep mode select
	input  wire logic       i_xtal_clk,      // Crystal clock option selected
	input  wire logic       i_t2_async,      // timer2_async_select
	input  wire logic       i_comp_disable,  // comparator_disable
	output logic            o_legal,         // Mode may be entered
	output clk_en_t         o_en,            // Clock enables while asleep
	output logic [8:0]      o_wake_allow     // Allowed sources, wake_src_t order
);
	// ----------------------------------------
	// Mode table
	// ----------------------------------------
	// Combinational so the table has one home; the caller registers its outputs
	always_comb begin
		o_legal = 1'b1;
		o_en = '0;
		o_wake_allow = 9'h000;
		case (i_mode)
			MODE_IDLE: begin
				o_en = '{core: 1'b0, prog_mem: 1'b0, periph: 1'b1, conv: 1'b1,
					async_tmr: 1'b1, main_osc: 1'b1, timer_osc: i_t2_async};
				o_wake_allow = 9'h1ff;
			end
			MODE_NOISE_RED: begin
				o_en = '{core: 1'b0, prog_mem: 1'b0, periph: 1'b0, conv: 1'b1,
					async_tmr: 1'b1, main_osc: 1'b1, timer_osc: i_t2_async};
				o_wake_allow = 9'h0ff;
			end
			MODE_POWER_DOWN: begin
				o_en = '0;
				o_wake_allow = 9'h079;
			end
			MODE_POWER_SAVE: begin
				o_en = '0;
				o_en.async_tmr = i_t2_async;
				o_en.timer_osc = i_t2_async;
				// Without async clocking the timer is frozen; its state is not trusted
				o_wake_allow = {1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, i_t2_async, 1'b0, 1'b1};
			end
			MODE_STANDBY: begin
				o_legal = i_xtal_clk;
				o_en = '0;
				o_en.main_osc = 1'b1;
				o_wake_allow = {1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
			end
			default: begin
				o_legal = 1'b0;
			end
		endcase
		// Comparator power gate does not alter the mode table
		if (i_comp_disable) begin
			o_wake_allow = o_wake_allow;
		end
	end
endmodule
`default_nettype wire

// ---- core/wake_delay_counter.sv ----
// Down counter that times the start-up and halt phases of a wake-up.
// Assumes a load pulse starts it; it reports done for one cycle when it reaches one.
`default_nettype none
module wake_delay_counter #(
	parameter int WIDTH = 16                // Counter width
) (
	input  wire logic             i_ref_clk, // Reference clock
	input  wire logic             i_rst,     // Synchronous reset
	input  wire logic             i_load,    // Load pulse
	input  wire logic [WIDTH-1:0] i_count,   // Cycles to count, at least one
	output logic                  o_done     // One-cycle pulse at the last cycle
);
	logic [WIDTH-1:0] remain;
	logic             busy;

	// ----------------------------------------
	// Count
	// ----------------------------------------
	// Zero load is treated as one so the phase never stalls
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			remain <= '0;
			busy <= 1'b0;
		end else if (i_load) begin
			remain <= (i_count == '0) ? WIDTH'(1) : i_count;
			busy <= 1'b1;
		end else if (busy) begin
			remain <= remain - WIDTH'(1);
			if (remain == WIDTH'(1)) begin
				busy <= 1'b0;
			end
		end
	end

	assign o_done = busy && (remain == WIDTH'(1));
endmodule
`default_nettype wire

// ---- core/sleep_mode_clock_gating.sv ----
// Sleep controller: enters the selected sleep mode on the sleep instruction,
// gates the clock domains, watches wake-up sources and times the resume.
// Assumes wake sources arrive from asynchronous logic and are synchronised here;
// the core pulses i_sleep_exec for one cycle when it executes the instruction.
//
// What this block does
// - Decode select field into five sleep modes
// - Standby only with crystal clock option
// - Idle stops core and program clocks, and timer osc if not async
// - Idle wakes on any enabled interrupt
// - Auto conversion start on idle, noise entry
// - Noise mode also stops peripheral clock
// - Noise mode wake only from listed sources
// - Power-down stops oscillator and all clocks
// - Power-down wakes on resets, match, level
// - Power-down exit waits fuse start-up delay
// - Power-save keeps async timer two running
// - Non-async power-save leaves timer undefined
// - Standby keeps oscillator, resumes in six
// - Comparator disable powers comparator down
// - Interrupt wake halts four plus start-up
`default_nettype none
module sleep_mode_clock_gating
	import sleep_ctrl_pkg::*;
#(
	parameter int CNT_WIDTH = 16            // Delay counter width
) (
	input  wire logic                 i_ref_clk,        // 200 MHz reference clock
	input  wire logic                 i_rst,            // Synchronous reset, active high
	input  wire logic                 i_sleep_exec,     // Sleep instruction pulse
	input  wire logic                 i_sleep_arm,      // sleep_arm bit
	input  wire logic [2:0]           i_sleep_mode_sel, // sleep_mode_select field
	input  wire logic                 i_xtal_clk,       // Crystal clock option
	input  wire logic [CNT_WIDTH-1:0] i_startup_cycles, // Fuse-selected start-up
	input  wire logic                 i_t2_async,       // timer2_async_select
	input  wire logic                 i_comp_disable,   // comparator_disable
	input  wire logic                 i_conv_enable,    // Converter enabled
	input  wire wake_src_t            i_wake,           // Wake sources, async
	output clk_en_t                   o_clk_en,         // Clock domain enables
	output logic                      o_comp_power,     // Comparator powered
	output logic                      o_conv_start,     // Auto conversion start
	output logic                      o_asleep,         // In a sleep mode
	output logic                      o_core_halt,      // Core held halted
	output logic                      o_irq_resume,     // Resume into handler
	output logic                      o_reset_wake      // Woke by a reset
);
	sleep_state_t state;
	sleep_state_t next_state;
	wake_src_t    wake_meta;
	wake_src_t    wake_sync;
	logic         legal;
	clk_en_t      dec_en;
	logic [8:0]   dec_allow;
	logic [8:0]   allow;
	logic [2:0]   mode;
	logic         wake_hit;
	logic         reset_hit;
	logic         start_load;
	logic         halt_load;
	logic         start_done;
	logic         halt_done;
	logic [CNT_WIDTH-1:0] start_count;
	logic         enter;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Two stages; only the second is read by logic. A short level pulse may be
	// missed here, which is why the source must hold it
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			wake_meta <= '0;
			wake_sync <= '0;
		end else begin
			wake_meta <= i_wake;
			wake_sync <= wake_meta;
		end
	end

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	sleep_mode_decode u_decode (
		.i_mode         (i_sleep_mode_sel),
		.i_xtal_clk     (i_xtal_clk),
		.i_t2_async     (i_t2_async),
		.i_comp_disable (i_comp_disable),
		.o_legal        (legal),
		.o_en           (dec_en),
		.o_wake_allow   (dec_allow)
	);

	// Sleep only when armed and the code is legal
	assign enter = i_sleep_exec && i_sleep_arm && legal && (state == ST_RUN);

	// Wake and reset qualification against the latched mode
	assign wake_hit  = |(allow & wake_sync);
	assign reset_hit = wake_sync.ext_reset || wake_sync.wdt_reset || wake_sync.bod_reset;

	// ----------------------------------------
	// Latched sleep context
	// ----------------------------------------
	// Mode is frozen at entry so software writes during sleep cannot move it
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			mode <= MODE_IDLE;
			allow <= 9'h000;
		end else if (enter) begin
			mode <= i_sleep_mode_sel;
			allow <= dec_allow;
		end
	end

	// ----------------------------------------
	// Start-up delay selection
	// ----------------------------------------
	// Standby keeps the oscillator, so a fixed short resume applies
	// stopped-oscillator modes wait the fuse delay others take one cycle
	always_comb begin
		start_count = CNT_WIDTH'(1);
		case (mode)
			MODE_STANDBY: start_count = CNT_WIDTH'(STANDBY_CYCLES);
			MODE_POWER_DOWN,
			MODE_POWER_SAVE: start_count = i_startup_cycles;
			default: start_count = CNT_WIDTH'(1);
		endcase
	end

	assign start_load = (state == ST_SLEEP) && wake_hit;
	assign halt_load  = (state == ST_START) && start_done && !o_reset_wake;

	wake_delay_counter #(
		.WIDTH (CNT_WIDTH)
	) u_start (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_load    (start_load),
		.i_count   (start_count),
		.o_done    (start_done)
	);

	wake_delay_counter #(
		.WIDTH (CNT_WIDTH)
	) u_halt (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_load    (halt_load),
		.i_count   (CNT_WIDTH'(WAKE_HALT_CYCLES)),
		.o_done    (halt_done)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN:   if (enter) next_state = ST_SLEEP;
			ST_SLEEP: if (wake_hit) next_state = ST_START;
			ST_START: begin
				if (start_done) begin
					next_state = o_reset_wake ? ST_RUN : ST_HALT;
				end
			end
			ST_HALT:  if (halt_done) next_state = ST_RUN;
			default:  next_state = ST_RUN;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state <= ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Remember a reset wake so the core restarts from its reset vector
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_reset_wake <= 1'b0;
		end else if (start_load) begin
			o_reset_wake <= reset_hit;
		end else if (state == ST_RUN) begin
			o_reset_wake <= 1'b0;
		end
	end

	// ----------------------------------------
	// Clock gating outputs
	// ----------------------------------------
	// Enables held in flops so the clock tree sees glitch-free levels
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_clk_en <= '1;
		end else if (enter) begin
			o_clk_en <= dec_en;
		end else if (start_load) begin
			o_clk_en <= '{core: 1'b0, prog_mem: 1'b0, periph: 1'b1, conv: 1'b1,
				async_tmr: 1'b1, main_osc: 1'b1, timer_osc: i_t2_async};
		end else if (next_state == ST_RUN && state != ST_RUN) begin
			o_clk_en <= '1;
		end
	end

	// Comparator is off on request, and always off in the deep modes
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_comp_power <= 1'b1;
		end else if (enter) begin
			o_comp_power <= !i_comp_disable && dec_en.periph;
		end else if (state == ST_RUN) begin
			o_comp_power <= !i_comp_disable;
		end
	end

	// One-cycle conversion start on entry to idle or noise reduction
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_conv_start <= 1'b0;
		end else begin
			o_conv_start <= enter && i_conv_enable &&
				(i_sleep_mode_sel == MODE_IDLE || i_sleep_mode_sel == MODE_NOISE_RED);
		end
	end

	// Status levels and the one-cycle resume pulse
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_asleep <= 1'b0;
			o_core_halt <= 1'b0;
			o_irq_resume <= 1'b0;
		end else begin
			o_asleep <= (next_state == ST_SLEEP);
			o_core_halt <= (next_state != ST_RUN);
			o_irq_resume <= (state == ST_HALT) && halt_done;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	reserved_no_sleep_a: assert property ((i_sleep_exec && state == ST_RUN &&
		(i_sleep_mode_sel == 3'h4 || i_sleep_mode_sel == 3'h5 || i_sleep_mode_sel == 3'h7))
		|=> !o_asleep) else $error("reserved code entered sleep");
	standby_xtal_a: assert property ((i_sleep_exec && i_sleep_arm && state == ST_RUN &&
		i_sleep_mode_sel == MODE_STANDBY && !i_xtal_clk) |=> !o_asleep)
		else $error("standby entered without crystal");
	unarmed_a: assert property ((i_sleep_exec && !i_sleep_arm && state == ST_RUN) |=> !o_asleep)
		else $error("sleep without arm");
	idle_clocks_a: assert property ((enter && i_sleep_mode_sel == MODE_IDLE) |=>
		(!o_clk_en.core && !o_clk_en.prog_mem && o_clk_en.periph && o_clk_en.conv))
		else $error("idle clock enables wrong");
	noise_clocks_a: assert property ((enter && i_sleep_mode_sel == MODE_NOISE_RED) |=>
		(!o_clk_en.periph && o_clk_en.conv && o_clk_en.main_osc)) else $error("noise clocks wrong");
	pdown_osc_a: assert property ((enter && i_sleep_mode_sel == MODE_POWER_DOWN) |=>
		(o_clk_en == '0)) else $error("power-down left a clock on");
	psave_timer_a: assert property ((enter && i_sleep_mode_sel == MODE_POWER_SAVE) |=>
		(o_clk_en.async_tmr == $past(i_t2_async))) else $error("power-save timer clock wrong");
	standby_osc_a: assert property ((enter && i_sleep_mode_sel == MODE_STANDBY) |=>
		(o_clk_en.main_osc && !o_clk_en.core)) else $error("standby oscillator off");
	standby_resume_a: assert property ((state == ST_SLEEP && wake_hit && mode == MODE_STANDBY)
		|=> (state == ST_START) [*6] ##1 (state != ST_START)) else $error("standby resume not six");
	halt_four_a: assert property ($rose(state == ST_HALT) |-> (state == ST_HALT) [*4]
		##1 (state == ST_RUN)) else $error("halt not four cycles");
	conv_start_a: assert property ((enter && i_conv_enable && i_sleep_mode_sel == MODE_NOISE_RED)
		|=> o_conv_start) else $error("no conversion start");
	pdown_no_irq_a: assert property ((state == ST_SLEEP && mode == MODE_POWER_DOWN &&
		!wake_sync.ext_level && !wake_sync.twi_match && !reset_hit) |=> (state != ST_START))
		else $error("power-down woke on wrong source");
	noise_no_irq_a: assert property ((state == ST_SLEEP && mode == MODE_NOISE_RED &&
		(9'(wake_sync) & 9'h0ff) == 9'h000) |=> (state != ST_START))
		else $error("noise mode woke on wrong source");

	// Wake-side walk: which sources wake, and how the core is let go afterwards
	idle_wake_a: assert property ((state == ST_SLEEP && mode == MODE_IDLE && wake_sync.any_irq)
		|=> (state == ST_START)) else $error("idle missed an interrupt wake");
	psave_t2_wake_a: assert property ((state == ST_SLEEP && mode == MODE_POWER_SAVE &&
		wake_sync.timer2_irq && o_clk_en.async_tmr) |=> (state == ST_START))
		else $error("power-save missed a timer wake");
	reset_no_halt_a: assert property ((state == ST_START && start_done && o_reset_wake)
		|=> (state == ST_RUN && !o_core_halt && !o_irq_resume)) else $error("reset wake went through halt");
	resume_pulse_a: assert property (o_irq_resume |-> (state == ST_RUN && !o_core_halt &&
		o_clk_en == '1) ##1 !o_irq_resume) else $error("resume pulse wrong");

	// Entry-side effects on the converter and the comparator
	conv_idle_a: assert property ((enter && i_conv_enable && i_sleep_mode_sel == MODE_IDLE)
		|=> o_conv_start) else $error("no conversion start in idle");
	conv_deep_a: assert property ((enter && i_sleep_mode_sel != MODE_IDLE &&
		i_sleep_mode_sel != MODE_NOISE_RED) |=> !o_conv_start) else $error("conversion start in deep mode");
	comp_off_a: assert property ((enter && i_comp_disable) |=> !o_comp_power)
		else $error("comparator powered while disabled");

	// Main scenarios the bench is expected to reach
	idle_wake_c: cover property ((state == ST_SLEEP && mode == MODE_IDLE) ##1 state == ST_START);
	psave_wake_c: cover property ((state == ST_SLEEP && mode == MODE_POWER_SAVE) ##1 state == ST_START);
	pdown_wake_c: cover property ((state == ST_START && mode == MODE_POWER_DOWN) ##1 state == ST_HALT);
	reset_wake_c: cover property (o_reset_wake && state == ST_START);
	resume_c: cover property (o_irq_resume);
endmodule
`default_nettype wire

// ---- testbench/sleep_partner_model.sv ----
// Behavioural model of the core and the wake-up sources facing the sleep controller.
// Assumes the bench pulses i_req and i_raise for one cycle, driven on the rising edge.
`default_nettype none
module sleep_partner_model
	import sleep_ctrl_pkg::*;
(
	input  wire logic       i_ref_clk, // Reference clock
	input  wire logic       i_rst,     // Synchronous reset
	input  wire logic       i_req,     // Run one sleep instruction
	input  wire logic       i_arm,     // Arm value written before it
	input  wire logic [8:0] i_raise,   // Wake sources to raise
	output logic            o_arm,     // sleep_arm bit
	output logic            o_exec,    // Sleep instruction pulse
	output wake_src_t       o_wake     // Wake source levels
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       pend;
	logic [2:0] hold;

	// Arm bit is written one cycle before the instruction runs
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_arm <= 1'b0;
			pend <= 1'b0;
			o_exec <= 1'b0;
		end else begin
			if (i_req) begin
				o_arm <= i_arm;
			end
			pend <= i_req;
			o_exec <= pend;
		end
	end

	// Level held five cycles so the synchroniser cannot miss it
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_wake <= '0;
			hold <= 3'h0;
		end else if (|i_raise) begin
			o_wake <= wake_src_t'(i_raise);
			hold <= 3'h5;
		end else if (hold != 3'h0) begin
			hold <= hold - 3'h1;
			if (hold == 3'h1) begin
				o_wake <= '0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- testbench/sleep_mode_clock_gating_tb.sv ----
// Self-checking bench for the sleep controller: sleeps in every mode and wakes it.
// Assumes the partner model stands in for the core and the wake-up sources.
`default_nettype none
module sleep_mode_clock_gating_tb;
	import sleep_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic        i_ref_clk;
	logic        i_rst;
	logic        req;
	logic        arm;
	logic [8:0]  raise;
	logic [2:0]  mode;
	logic [3:0]  cfg;
	logic        sleep_arm;
	logic        sleep_exec;
	wake_src_t   wake;
	clk_en_t     clk_en;
	logic        comp_power;
	logic        conv_start;
	logic        asleep;
	logic        core_halt;
	logic        irq_resume;
	logic        reset_wake;
	int          err_count;
	int          checks_done;
	int          cycles;
	int          halt_cnt;
	int          conv_cnt;
	int          resume_cnt;
	int          rw_cnt;

	sleep_partner_model sleep_partner_model_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req(req), .i_arm(arm),
		.i_raise(raise), .o_arm(sleep_arm), .o_exec(sleep_exec), .o_wake(wake));

	// cfg holds {crystal, timer2 async, comparator disable, converter enable}
	sleep_mode_clock_gating sleep_mode_clock_gating_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_sleep_exec(sleep_exec), .i_sleep_arm(sleep_arm), .i_sleep_mode_sel(mode), .i_xtal_clk(cfg[3]),
		.i_startup_cycles(16'h000a), .i_t2_async(cfg[2]), .i_comp_disable(cfg[1]), .i_conv_enable(cfg[0]),
		.i_wake(wake), .o_clk_en(clk_en), .o_comp_power(comp_power), .o_conv_start(conv_start),
		.o_asleep(asleep), .o_core_halt(core_halt), .o_irq_resume(irq_resume), .o_reset_wake(reset_wake));

	// ----------------------------------------
	// Clock, monitors and timeout
	// ----------------------------------------
	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end

	// Counts wake-phase cycles and pulses; the ceiling cuts a hang short
	always @(posedge i_ref_clk) begin
		cycles++;
		if (core_halt === 1'b1 && asleep === 1'b0) halt_cnt++;
		if (conv_start === 1'b1) conv_cnt++;
		if (irq_resume === 1'b1) resume_cnt++;
		if (reset_wake === 1'b1) rw_cnt++;
		if (cycles == 20000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Clock enables expected while asleep: {core,prog,periph,conv,async,main,tosc}
	function automatic logic [6:0] exp_en(input logic [2:0] m, input logic t2);
		case (m)
			MODE_IDLE:      return {6'h0f, t2};
			MODE_NOISE_RED: return {6'h07, t2};
			MODE_POWER_SAVE: return {4'h0, t2, 1'b0, t2};
			MODE_STANDBY:   return 7'h02;
			default:        return 7'h00;
		endcase
	endfunction

	task automatic pulse_raise(input logic [8:0] bits);
		@(posedge i_ref_clk);
		raise <= bits;
		@(posedge i_ref_clk);
		raise <= 9'h000;
	endtask

	// One sleep: enter, try a source that must not wake, then wake; cnt < 0 means refused
	task automatic nap(input logic [2:0] m, input logic [3:0] c, input logic a, input logic [8:0] bad,
		input logic [8:0] good, input int cnt, input logic by_irq);
		int n;
		@(negedge i_ref_clk);
		halt_cnt = 0;
		conv_cnt = 0;
		resume_cnt = 0;
		rw_cnt = 0;
		@(posedge i_ref_clk);
		mode <= m;
		cfg <= c;
		arm <= a;
		req <= 1'b1;
		@(posedge i_ref_clk);
		req <= 1'b0;
		n = 0;
		while (asleep !== 1'b1 && n < 8) begin
			@(negedge i_ref_clk);
			n++;
		end
		if (cnt < 0) begin
			chk(16'(asleep), 16'h0, "refused sleep entered");
			chk(16'(clk_en), 16'h7f, "refused clocks");
			return;
		end
		chk(16'(clk_en), 16'(exp_en(m, c[2])), "sleep clocks");
		chk(16'(comp_power), 16'(m == MODE_IDLE && !c[1]), "comparator power");
		if (bad != 9'h000) begin
			pulse_raise(bad);
			repeat (14) @(negedge i_ref_clk);
			chk(16'(asleep), 16'h1, "woke on masked source");
		end
		pulse_raise(good);
		n = 0;
		while (core_halt !== 1'b0 && n < 200) begin
			@(negedge i_ref_clk);
			n++;
		end
		@(negedge i_ref_clk);
		chk(16'(halt_cnt), 16'(cnt), "wake delay");
		chk(16'(resume_cnt), 16'(by_irq), "resume pulses");
		chk(16'(rw_cnt != 0), 16'(!by_irq), "reset wake flag");
		chk(16'(conv_cnt), 16'(m <= MODE_NOISE_RED && c[0]), "conversion starts");
		chk(16'(clk_en), 16'h7f, "clocks after wake");
	endtask

	task automatic wrap_up();
		$display("Mismatches %0d, comparisons %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		i_rst = 1'b1;
		req = 1'b0;
		arm = 1'b0;
		raise = 9'h000;
		mode = 3'h0;
		cfg = 4'hf;
		err_count = 0;
		checks_done = 0;
		cycles = 0;
		repeat (5) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(negedge i_ref_clk);
		chk(16'({clk_en, comp_power, asleep}), 16'h01fe, "reset outputs");
		nap(MODE_IDLE, 4'hf, 1'b1, 9'h000, 9'h100, 5, 1'b1);
		nap(MODE_IDLE, 4'hd, 1'b1, 9'h000, 9'h004, 5, 1'b1);
		nap(MODE_NOISE_RED, 4'hd, 1'b1, 9'h100, 9'h080, 5, 1'b1);
		nap(MODE_NOISE_RED, 4'hc, 1'b1, 9'h000, 9'h040, 1, 1'b0);
		nap(MODE_POWER_DOWN, 4'hc, 1'b1, 9'h002, 9'h001, 14, 1'b1);
		nap(MODE_POWER_DOWN, 4'hc, 1'b1, 9'h080, 9'h008, 14, 1'b1);
		nap(MODE_POWER_SAVE, 4'hc, 1'b1, 9'h002, 9'h004, 14, 1'b1);
		nap(MODE_POWER_SAVE, 4'h8, 1'b1, 9'h004, 9'h008, 14, 1'b1);
		nap(MODE_STANDBY, 4'hc, 1'b1, 9'h080, 9'h020, 6, 1'b0);
		nap(MODE_STANDBY, 4'hc, 1'b1, 9'h000, 9'h010, 6, 1'b0);
		for (int k = 4; k < 8; k++) begin
			if (k != 6) nap(3'(k), 4'hc, 1'b1, 9'h000, 9'h000, -1, 1'b0);
		end
		nap(MODE_STANDBY, 4'h4, 1'b1, 9'h000, 9'h000, -1, 1'b0);
		nap(MODE_IDLE, 4'hc, 1'b0, 9'h000, 9'h000, -1, 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
